// *** verilog/sfs_pkg.sv ***
// constants, states and field layout of the spi memory slave
package sfs_pkg;

  // ----------------------------------------------------------------
  // op-codes
  // ----------------------------------------------------------------
  localparam logic [7:0] SET_WRITE_LATCH_CMD   = 8'h06;
  localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
  localparam logic [7:0] READ_STATUS_CMD       = 8'h05;
  localparam logic [7:0] WRITE_STATUS_CMD      = 8'h01;
  localparam logic [7:0] READ_MEM_CMD          = 8'h03;
  localparam logic [7:0] WRITE_MEM_CMD         = 8'h02;

  // ----------------------------------------------------------------
  // array geometry and protection bounds
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 13;
  localparam int          DATA_W        = 8;
  localparam int          MEM_DEPTH     = 8192;
  localparam int          ADDR_HI_W     = 5;
  localparam logic [12:0] PROT_QTR_BASE = 13'h1800;
  localparam logic [12:0] PROT_HLF_BASE = 13'h1000;
  localparam logic [12:0] ADDR_TOP      = 13'h1fff;
  localparam logic [2:0]  BIT_LAST      = 3'h7;

  // ----------------------------------------------------------------
  // status byte field positions and reset values
  // ----------------------------------------------------------------
  localparam int   STAT_WPEN_POS = 7;
  localparam int   STAT_BPH_POS  = 3;
  localparam int   STAT_BPL_POS  = 2;
  localparam int   STAT_WEL_POS  = 1;
  localparam logic WEL_RST       = 1'b0;
  localparam logic WPEN_RST      = 1'b0;
  localparam logic BP_RST        = 1'b0;

  // ----------------------------------------------------------------
  // synchroniser bit positions and idle values
  // ----------------------------------------------------------------
  localparam int         SYN_CS   = 4;
  localparam int         SYN_SCK  = 3;
  localparam int         SYN_SI   = 2;
  localparam int         SYN_HOLD = 1;
  localparam int         SYN_WP   = 0;
  localparam logic [4:0] SYN_RST  = 5'h13;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SCK_MAX_KHZ = 5000;
  localparam int BUF_DEPTH   = 2;

  // ----------------------------------------------------------------
  // protocol states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_OP      = 3'b001,
    ST_ADDR    = 3'b010,
    ST_DATA_WR = 3'b011,
    ST_DATA_RD = 3'b100,
    ST_STAT_RD = 3'b101,
    ST_STAT_WR = 3'b110,
    ST_IGNORE  = 3'b111
  } sfs_state_t;

endpackage : sfs_pkg

// *** verilog/sfs_buf_if.sv ***
// carrier between the slave and its write buffer
`timescale 1ns/1ps
interface sfs_buf_if #(
  parameter int WIDTH = 21
);
  logic             push_valid;
  logic             push_ready;
  logic [WIDTH-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic [WIDTH-1:0] pop_data;

  modport owner (
    output push_valid,
    output push_data,
    input  push_ready,
    input  pop_valid,
    input  pop_data,
    output pop_ready
  );

  modport fifo (
    input  push_valid,
    input  push_data,
    output push_ready,
    output pop_valid,
    output pop_data,
    input  pop_ready
  );
endinterface : sfs_buf_if

// *** verilog/sfs_buffer.sv ***
// two-entry valid/ready buffer for array write words
`timescale 1ns/1ps
module sfs_buffer #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 2
) (
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  sfs_buf_if.fifo   bif
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] ent;
    logic [PW-1:0]               wptr;
    logic [PW-1:0]               rptr;
    logic [CW-1:0]               cnt;
  } sfs_buf_st_t;

  sfs_buf_st_t q;
  sfs_buf_st_t d;
  logic        do_push;
  logic        do_pop;

  // ----------------------------------------------------------------
  // pointer and count update
  // ----------------------------------------------------------------
  always_comb begin
    d       = q;
    do_push = bif.push_valid && (q.cnt != CW'(DEPTH));
    do_pop  = bif.pop_ready && (q.cnt != '0);
    if (do_push) begin
      d.ent[q.wptr] = bif.push_data;
      d.wptr        = (q.wptr == PW'(DEPTH - 1)) ? '0 : PW'(q.wptr + 1'b1);
    end
    if (do_pop) begin
      d.rptr = (q.rptr == PW'(DEPTH - 1)) ? '0 : PW'(q.rptr + 1'b1);
    end
    if (do_push && !do_pop) begin
      d.cnt = CW'(q.cnt + 1'b1);
    end else if (!do_push && do_pop) begin
      d.cnt = CW'(q.cnt - 1'b1);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bif.push_ready = (q.cnt != CW'(DEPTH));
  assign bif.pop_valid  = (q.cnt != '0);
  assign bif.pop_data   = q.ent[q.rptr];

endmodule : sfs_buffer

// *** verilog/sfs_slave.sv ***
// spi slave front end and array of the serial ferroelectric memory
`timescale 1ns/1ps
module sfs_slave
  import sfs_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic cs_n_i,
  input  wire logic sck_i,
  input  wire logic si_i,
  input  wire logic hold_n_i,
  input  wire logic wp_n_i,
  output logic      so_o,
  output logic      so_oe_n_o
);

  localparam int BW = ADDR_W + DATA_W;

  typedef struct packed {
    logic [4:0]          s1;
    logic [4:0]          s2;
    logic                cs_p;
    logic                sck_p;
    sfs_state_t          state;
    logic [2:0]          cnt;
    logic [2:0]          ocnt;
    logic [7:0]          in_sh;
    logic [7:0]          out_sh;
    logic                addr_hi_done;
    logic                rd_op;
    logic [ADDR_W-1:0]   addr;
    logic                fetch;
    logic                write_enable_latch;
    logic                wpen;
    logic                bp_hi;
    logic                bp_lo;
    logic                wr_op;
    logic                so;
    logic                oe_n;
    logic                drv;
  } sfs_slave_st_t;

  sfs_slave_st_t     q;
  sfs_slave_st_t     d;
  logic [DATA_W-1:0] mem [MEM_DEPTH];
  logic              cs_s;
  logic              sck_s;
  logic              si_s;
  logic              hold_s;
  logic              wp_s;
  logic              active;
  logic              sck_rise;
  logic              sck_fall;
  logic              cs_fall;
  logic              byte_done;
  logic [7:0]        byte_v;
  logic [7:0]        status_v;
  logic              push_v;
  logic [BW-1:0]     push_w;

  sfs_buf_if #(.WIDTH(BW)) bif ();

  sfs_buffer #(
    .WIDTH (BW),
    .DEPTH (BUF_DEPTH)
  ) u_wbuf (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .bif        (bif)
  );

  // ----------------------------------------------------------------
  // synchronised pins and edges
  // ----------------------------------------------------------------
  assign cs_s     = q.s2[SYN_CS];
  assign sck_s    = q.s2[SYN_SCK];
  assign si_s     = q.s2[SYN_SI];
  assign hold_s   = q.s2[SYN_HOLD];
  assign wp_s     = q.s2[SYN_WP];
  assign active   = !cs_s && hold_s;
  assign sck_rise = active && sck_s && !q.sck_p;
  assign sck_fall = active && !sck_s && q.sck_p;
  assign cs_fall  = hold_s && !cs_s && q.cs_p;
  assign byte_done = sck_rise && (q.state != ST_IDLE) && (q.cnt == BIT_LAST);

  always_comb begin
    status_v                = '0;
    status_v[STAT_WPEN_POS] = q.wpen;
    status_v[STAT_BPH_POS]  = q.bp_hi;
    status_v[STAT_BPL_POS]  = q.bp_lo;
    status_v[STAT_WEL_POS]  = q.write_enable_latch;
  end

  function automatic logic prot_hit(input logic bh, input logic bl,
                                    input logic [ADDR_W-1:0] a);
    logic r;
    case ({bh, bl})
      2'b00:   r = 1'b0;
      2'b01:   r = (a >= PROT_QTR_BASE);
      2'b10:   r = (a >= PROT_HLF_BASE);
      default: r = 1'b1;
    endcase
    return r;
  endfunction : prot_hit

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  always_comb begin
    d       = q;
    push_v  = 1'b0;
    push_w  = {q.addr, q.in_sh};
    byte_v  = {q.in_sh[6:0], si_s};
    d.s1    = {cs_n_i, sck_i, si_i, hold_n_i, wp_n_i};
    d.s2    = q.s1;
    d.cs_p  = cs_s;
    d.sck_p = sck_s;
    d.fetch = 1'b0;
    d.oe_n  = !q.drv;
    if (q.fetch) begin
      d.out_sh = mem[q.addr];
      d.addr   = ADDR_W'(q.addr + 1'b1);
    end
    if (!hold_s) begin
      d.oe_n = 1'b1;
    end else if (cs_s) begin
      d.state = ST_IDLE;
      d.oe_n  = 1'b1;
      d.wr_op = 1'b0;
      d.drv   = 1'b0;
      if (q.wr_op) begin
        d.write_enable_latch = 1'b0;
      end
    end else if (cs_fall) begin
      d.state        = ST_OP;
      d.cnt          = '0;
      d.addr_hi_done = 1'b0;
    end else if (sck_rise && q.state != ST_IDLE) begin
      d.in_sh = byte_v;
      d.cnt   = 3'(q.cnt + 1'b1);
      d.oe_n  = 1'b1;
      d.drv   = 1'b0;
      if (q.cnt == BIT_LAST) begin
        case (q.state)
          ST_OP: begin
            d.state = ST_IGNORE;
            case (byte_v)
              SET_WRITE_LATCH_CMD:   d.write_enable_latch = 1'b1;
              CLEAR_WRITE_LATCH_CMD: d.write_enable_latch = 1'b0;
              READ_STATUS_CMD: begin
                d.state  = ST_STAT_RD;
                d.out_sh = status_v;
                d.ocnt   = '0;
              end
              WRITE_STATUS_CMD: begin
                d.state = ST_STAT_WR;
                d.wr_op = 1'b1;
              end
              READ_MEM_CMD: begin
                d.state = ST_ADDR;
                d.rd_op = 1'b1;
              end
              WRITE_MEM_CMD: begin
                d.state = ST_ADDR;
                d.rd_op = 1'b0;
                d.wr_op = 1'b1;
              end
              default: d.state = ST_IGNORE;
            endcase
          end
          ST_ADDR: begin
            if (!q.addr_hi_done) begin
              d.addr[ADDR_W-1:8] = byte_v[ADDR_HI_W-1:0];
              d.addr_hi_done     = 1'b1;
            end else begin
              d.addr[7:0] = byte_v;
              if (q.rd_op) begin
                d.state = ST_DATA_RD;
                d.fetch = 1'b1;
                d.ocnt  = '0;
              end else begin
                d.state = ST_DATA_WR;
              end
            end
          end
          ST_DATA_WR: begin
            push_w = {q.addr, byte_v};
            push_v = q.write_enable_latch && !prot_hit(q.bp_hi, q.bp_lo, q.addr)
                     && bif.push_ready;
            d.addr = ADDR_W'(q.addr + 1'b1);
          end
          ST_STAT_WR: begin
            if (q.write_enable_latch && !(q.wpen && !wp_s)) begin
              d.wpen  = byte_v[STAT_WPEN_POS];
              d.bp_hi = byte_v[STAT_BPH_POS];
              d.bp_lo = byte_v[STAT_BPL_POS];
            end
            d.state = ST_IGNORE;
          end
          default: d.state = q.state;
        endcase
      end
    end else if (sck_fall && (q.state == ST_DATA_RD || q.state == ST_STAT_RD)) begin
      d.so     = q.out_sh[7];
      d.oe_n   = 1'b0;
      d.drv    = 1'b1;
      d.out_sh = {q.out_sh[6:0], 1'b0};
      d.ocnt   = 3'(q.ocnt + 1'b1);
      if (q.ocnt == BIT_LAST) begin
        if (q.state == ST_DATA_RD) begin
          d.fetch = 1'b1;
        end else begin
          d.out_sh = status_v;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // state register and array
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      q       <= '0;
      q.s1    <= SYN_RST;
      q.s2    <= SYN_RST;
      q.cs_p  <= 1'b1;
      q.state <= ST_IDLE;
      q.write_enable_latch   <= WEL_RST;
      q.wpen  <= WPEN_RST;
      q.bp_hi <= BP_RST;
      q.bp_lo <= BP_RST;
      q.oe_n  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign bif.push_valid = push_v;
  assign bif.push_data  = push_w;
  assign bif.pop_ready  = !q.fetch;

  always_ff @(posedge core_clk_i) begin
    if (bif.pop_valid && bif.pop_ready) begin
      mem[bif.pop_data[BW-1:DATA_W]] <= bif.pop_data[DATA_W-1:0];
    end
  end

  assign so_o      = q.so;
  assign so_oe_n_o = q.oe_n;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_wr_complete;
    q.wr_op ##1 (cs_s && hold_s);
  endsequence

  sequence s_rx_bit;
    sck_rise && q.state != ST_IDLE;
  endsequence

  AST_CS_HIGH_RELEASE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (cs_s && hold_s) |=> q.oe_n && q.state == ST_IDLE)
    else $error("output driven or engine busy while deselected");

  AST_HOLD_FREEZE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !hold_s |=> $stable(q.state) && $stable(q.cnt) && $stable(q.addr) && q.oe_n)
    else $error("engine moved or drove output during hold");

  AST_RX_NO_DRIVE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    s_rx_bit |=> q.oe_n)
    else $error("output driven while receiving a bit");

  AST_SO_ON_FALL: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (($fell(q.oe_n) && $past(hold_s, 2)) || (!q.oe_n && $changed(q.so))) |-> $past(sck_fall))
    else $error("serial output changed away from a falling edge");

  AST_CNT_ON_RISE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    ($changed(q.cnt) && !$past(cs_fall)) |-> $past(sck_rise))
    else $error("input bit count moved without a rising edge");

  AST_WP_GUARD: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (byte_done && q.state == ST_STAT_WR && q.wpen && !wp_s)
      |=> $stable(q.wpen) && $stable(q.bp_hi) && $stable(q.bp_lo))
    else $error("status written while write-protected");

  AST_WEL_AUTO_CLEAR: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    s_wr_complete |=> !q.write_enable_latch)
    else $error("write latch survived a completed write");

  AST_PROT_NO_PUSH: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    push_v |-> q.write_enable_latch && !prot_hit(q.bp_hi, q.bp_lo, q.addr))
    else $error("protected or unlatched array write accepted");

  AST_ADDR_WRAP: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (byte_done && q.state == ST_DATA_WR && q.addr == ADDR_TOP) |=> q.addr == '0)
    else $error("write address failed to wrap to zero");

  AST_WRITE_DRAIN: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    bif.pop_valid |-> ##[0:2] (bif.pop_valid && bif.pop_ready))
    else $error("buffered array write not drained in time");

  AST_ADDR_COMPLETE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (byte_done && q.state == ST_ADDR && q.addr_hi_done)
      |=> q.state == ST_DATA_RD || q.state == ST_DATA_WR)
    else $error("data phase not entered after two address bytes");

endmodule : sfs_slave

// *** testbench/sfs_master.sv ***
// spi bus master model driving the memory slave pins
`timescale 1ns/1ps
module sfs_master (
  input  wire logic core_clk_i,
  input  wire logic so_i,
  input  wire logic so_oe_n_i,
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      si_o,
  output logic      hold_n_o
);
  // half of the 48 ns link period in core cycles
  localparam int HALF = 6;
  logic idle_hi;

  initial begin
    cs_n_o   = 1'b1;
    sck_o    = 1'b0;
    si_o     = 1'b0;
    hold_n_o = 1'b1;
    idle_hi  = 1'b0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : wait_n

  task automatic open_frame(input logic mode3);
    idle_hi = mode3;
    sck_o   = mode3;
    wait_n(HALF);
    cs_n_o  = 1'b0;
    wait_n(HALF);
  endtask : open_frame

  task automatic close_frame();
    sck_o  = idle_hi;
    wait_n(HALF);
    cs_n_o = 1'b1;
    si_o   = ~si_o;
    wait_n(2 * HALF);
  endtask : close_frame

  // one byte; pause stretches bit 3, hold pauses it while pulsing sck and cs high twice
  task automatic xfer(input logic [7:0] tx, input int pause, input logic hold,
                      output logic [7:0] rx, output int oe_cnt, output logic oe_hold);
    oe_cnt  = 0;
    oe_hold = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sck_o = 1'b0;
      si_o  = tx[i];
      wait_n(HALF);
      if (i == 3) begin
        wait_n(pause);
        if (hold) begin
          hold_n_o = 1'b0;
          wait_n(HALF);
          repeat (2) begin
            sck_o  = 1'b1;
            cs_n_o = 1'b1;
            wait_n(HALF);
            oe_hold = oe_hold | (so_oe_n_i !== 1'b1);
            sck_o  = 1'b0;
            cs_n_o = 1'b0;
            wait_n(HALF);
          end
          hold_n_o = 1'b1;
          wait_n(HALF);
        end
      end
      // released line reads as the inverse
      rx[i] = (so_oe_n_i === 1'b0) ? so_i : ~so_i;
      if (so_oe_n_i === 1'b0) oe_cnt++;
      sck_o = 1'b1;
      wait_n(HALF);
    end
  endtask : xfer
endmodule : sfs_master

// *** testbench/spi_fram_slave_interface_test.sv ***
// self-checking bench of the spi memory slave
`timescale 1ns/1ps
module spi_fram_slave_interface_test;
  import sfs_pkg::*;
  logic        core_clk_i;
  logic        sys_rst_i;
  logic        cs_n;
  logic        sck;
  logic        si;
  logic        hold_n;
  logic        wp_n;
  logic        so;
  logic        so_oe_n;
  int          fails;
  int          checks_done;
  int          cycles;
  logic [15:0] rnd_q;
  logic [15:0] ra;
  int          rn;
  logic        rm;
  logic [7:0]  mem_m [0:8191];
  logic        latch_m;
  logic        wpen_m;
  logic [1:0]  bp_m;
  localparam logic [15:0] PA [4] = '{16'h0fff, 16'h1000, 16'h17ff, 16'h1800};

  sfs_slave dut_u (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n),
                   .sck_i(sck), .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n),
                   .so_o(so), .so_oe_n_o(so_oe_n));
  sfs_master m_u (.core_clk_i(core_clk_i), .so_i(so), .so_oe_n_i(so_oe_n),
                  .cs_n_o(cs_n), .sck_o(sck), .si_o(si), .hold_n_o(hold_n));

  initial core_clk_i = 1'b0;
  always #2 core_clk_i = ~core_clk_i;

  // ----------------------------------------------------------------
  // expectation functions
  // ----------------------------------------------------------------
  function automatic logic [15:0] next_rnd(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : next_rnd

  function automatic logic is_prot(input logic [12:0] a, input logic [1:0] bp);
    case (bp)
      2'b00:   return 1'b0;
      2'b01:   return a >= PROT_QTR_BASE;
      2'b10:   return a >= PROT_HLF_BASE;
      default: return 1'b1;
    endcase
  endfunction : is_prot

  function automatic logic [7:0] exp_status();
    return {wpen_m, 3'b000, bp_m, latch_m, 1'b0};
  endfunction : exp_status

  // ----------------------------------------------------------------
  // transfer tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    if (fails == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic xb(input logic [7:0] tx, input logic rd, input int pause,
                    input logic hold, output logic [7:0] rx);
    int   oe_cnt;
    logic oe_hold;
    m_u.xfer(tx, pause, hold, rx, oe_cnt, oe_hold);
    check("drive count", rd ? 8'h08 : 8'h00, 8'(oe_cnt));
    check("drive in hold", 8'h00, {7'h0, oe_hold});
  endtask : xb

  task automatic cmd(input logic [7:0] op);
    logic [7:0] rx;
    m_u.open_frame(1'b0);
    xb(op, 1'b0, 0, 1'b0, rx);
    m_u.close_frame();
    if (op == SET_WRITE_LATCH_CMD) latch_m = 1'b1;
    if (op == CLEAR_WRITE_LATCH_CMD) latch_m = 1'b0;
  endtask : cmd

  task automatic stat_write(input logic [7:0] v);
    logic [7:0] rx;
    m_u.open_frame(1'b0);
    xb(WRITE_STATUS_CMD, 1'b0, 0, 1'b0, rx);
    xb(v, 1'b0, 0, 1'b0, rx);
    m_u.close_frame();
    if (latch_m && !(wpen_m && !wp_n)) begin
      wpen_m = v[7];
      bp_m   = v[3:2];
    end
    latch_m = 1'b0;
  endtask : stat_write

  task automatic stat_read();
    logic [7:0] rx;
    m_u.open_frame(1'b1);
    xb(READ_STATUS_CMD, 1'b0, 0, 1'b0, rx);
    rnd_q = next_rnd(rnd_q);
    xb(rnd_q[7:0], 1'b1, 0, 1'b0, rx);
    check("status", exp_status(), rx);
    m_u.close_frame();
  endtask : stat_read

  task automatic mem_write(input logic [15:0] a, input int n, input logic m3);
    logic [7:0]  rx;
    logic [12:0] p;
    p = a[12:0];
    m_u.open_frame(m3);
    xb(WRITE_MEM_CMD, 1'b0, 0, 1'b0, rx);
    xb(a[15:8], 1'b0, 0, 1'b0, rx);
    xb(a[7:0], 1'b0, 0, 1'b0, rx);
    for (int i = 0; i < n; i++) begin
      rnd_q = next_rnd(rnd_q);
      xb(rnd_q[7:0], 1'b0, 0, 1'b0, rx);
      if (latch_m && !is_prot(p, bp_m)) mem_m[p] = rnd_q[7:0];
      p = p + 13'h1;
    end
    m_u.close_frame();
    latch_m = 1'b0;
  endtask : mem_write

  task automatic mem_read(input logic [15:0] a, input int n, input logic m3, input int hb);
    logic [7:0]  rx;
    logic [12:0] p;
    p = a[12:0];
    m_u.open_frame(m3);
    xb(READ_MEM_CMD, 1'b0, 0, 1'b0, rx);
    xb(a[15:8], 1'b0, 0, 1'b0, rx);
    xb(a[7:0], 1'b0, 0, 1'b0, rx);
    for (int i = 0; i < n; i++) begin
      rnd_q = next_rnd(rnd_q);
      xb(rnd_q[7:0], 1'b1, (i == hb) ? 40 : 0, i == hb, rx);
      check("read data", mem_m[p], rx);
      p = p + 13'h1;
    end
    m_u.close_frame();
  endtask : mem_read

  // ----------------------------------------------------------------
  // timeout and main sequence
  // ----------------------------------------------------------------
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      fails++;
      report_and_stop();
    end
  end

  initial begin
    sys_rst_i   = 1'b1;
    wp_n        = 1'b1;
    fails       = 0;
    checks_done = 0;
    cycles      = 0;
    rnd_q       = 16'ha2a2;
    latch_m     = 1'b0;
    wpen_m      = 1'b0;
    bp_m        = 2'b00;
    repeat (3) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    repeat (6) @(negedge core_clk_i);
    check("idle drive", 8'h01, {7'h0, so_oe_n});
    stat_read();
    cmd(SET_WRITE_LATCH_CMD);
    mem_write(16'h0010, 2, 1'b0);
    mem_write(16'h0010, 2, 1'b1);
    mem_read(16'he010, 2, 1'b0, 9);
    cmd(SET_WRITE_LATCH_CMD);
    mem_write(16'h1fff, 2, 1'b1);
    mem_read(16'h3fff, 2, 1'b0, 9);
    for (int k = 0; k < 6; k++) begin
      rnd_q = next_rnd(rnd_q);
      ra = rnd_q;
      rn = int'(rnd_q[9:8]) % 3 + 1;
      rm = rnd_q[5];
      cmd(SET_WRITE_LATCH_CMD);
      mem_write(ra, rn, rm);
      mem_read(ra ^ 16'he000, rn, ~rm, 9);
    end
    cmd(SET_WRITE_LATCH_CMD);
    stat_read();
    cmd(CLEAR_WRITE_LATCH_CMD);
    stat_read();
    for (int b = 0; b < 4; b++) begin
      cmd(SET_WRITE_LATCH_CMD);
      stat_write({4'h0, 2'(b), 2'b00});
      for (int j = 0; j < 4; j++) begin
        cmd(SET_WRITE_LATCH_CMD);
        mem_write(PA[j], 1, 1'b0);
        mem_read(PA[j], 1, 1'b1, 9);
      end
    end
    cmd(SET_WRITE_LATCH_CMD);
    stat_write(8'h80);
    wp_n = 1'b0;
    cmd(SET_WRITE_LATCH_CMD);
    stat_write(8'h0c);
    stat_read();
    cmd(SET_WRITE_LATCH_CMD);
    mem_write(16'h0200, 1, 1'b0);
    mem_read(16'h0200, 1, 1'b0, 9);
    wp_n = 1'b1;
    mem_read(16'h0010, 2, 1'b0, 1);
    report_and_stop();
  end
endmodule : spi_fram_slave_interface_test
